// ---- verilog/bpd_pkg.sv ----
// Package of the backup priority, delay and fault controller.
// Assumes a 50 MHz APB clock; shared by the design and its bench.
package bpd_pkg;
  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned TICK_MS = 500;
  localparam int unsigned TICK_CYC = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned QUAL_MS = 500;
  localparam int unsigned QUAL_TICKS = (QUAL_MS + TICK_MS - 1) / TICK_MS;
  localparam int unsigned LINK_BAUD = 9600;
  localparam logic LINK_EVEN = 1'b1;
  // ------------------------------------------------------------
  // Sizes and codes
  // ------------------------------------------------------------
  localparam int unsigned NPRIME = 8;
  localparam int unsigned NUNIT = 10;
  localparam int unsigned NDL = 7;
  localparam logic [1:0] RANK_HIGH = 2'h1;
  localparam logic [1:0] RANK_MED = 2'h2;
  localparam logic [1:0] RANK_LOW = 2'h3;
  localparam logic [1:0] DLY_NONE = 2'h1;
  localparam logic [1:0] DLY_MAN = 2'h2;
  localparam logic [1:0] DLY_AUTO = 2'h3;
  localparam logic [1:0] RX_DLY_DFLT = DLY_AUTO;
  localparam logic [1:0] TX_DLY_DFLT = DLY_NONE;
  localparam logic [1:0] UNSET = 2'h0;
  // ------------------------------------------------------------
  // Register byte offsets
  // ------------------------------------------------------------
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_RANK_TX = 8'h04;
  localparam logic [7:0] A_RANK_RX = 8'h08;
  localparam logic [7:0] A_MODE_TX = 8'h0C;
  localparam logic [7:0] A_MODE_RX = 8'h10;
  localparam logic [7:0] A_ACTIVE = 8'h14;
  localparam logic [7:0] A_DLMAP = 8'h18;
  localparam logic [7:0] A_CFG = 8'h1C;
  localparam logic [7:0] A_LINK = 8'h20;
  localparam logic [7:0] A_FLT_SW = 8'h24;
  localparam logic [7:0] A_FLT_SYS = 8'h28;
  localparam logic [7:0] A_FLT_AUX = 8'h2C;
  localparam logic [7:0] A_STATE = 8'h30;
  localparam logic [1:0] A_MAN_HI = 2'h1;
  localparam int unsigned SWEEP_LSB = 8;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_QUAL = 4'b0010,
    ST_WAIT = 4'b0100,
    ST_LIVE = 4'b1000
  } bpd_st_t;
endpackage

// ---- verilog/bpd_ctrl.sv ----
// Backup decision and fault-reporting core of an M:N protection switch.
// Assumes APB master on pclk and fault inputs synchronous to pclk.
`timescale 1ns/10ps
module bpd_ctrl #(
  parameter int unsigned TICK_CYC = bpd_pkg::TICK_CYC
) (
  input logic pclk,
  input logic presetn,
  input logic [7:0] paddr,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input logic [7:0] tx_fault,
  input logic [7:0] rx_fault,
  input logic bk_tx_fault,
  input logic bk_rx_lock,
  output logic [2:0] tx_bk_prime,
  output logic tx_bk_online,
  output logic [2:0] rx_bk_prime,
  output logic rx_bk_online,
  output logic cfg_start,
  output logic cfg_verify,
  output logic cfg_all,
  output logic [3:0] cfg_unit,
  input logic cfg_done,
  input logic cfg_pass,
  input logic [9:0] modem_cfg_changed,
  input logic [9:0] comm_fail,
  input logic [9:0] incompat,
  input logic [9:0] setup_missing,
  input logic [2:0] rail_fail,
  input logic [1:0] psu_fail,
  input logic battery_low,
  output logic [7:0] tx_backup_switch_fault,
  output logic [7:0] rx_backup_switch_fault,
  output logic [6:0] downlink_all_rx_fault,
  output logic lamp_tx,
  output logic lamp_rx,
  output logic lamp_sys,
  output logic lamp_batt
);
  import bpd_pkg::*;
  localparam int DW = $clog2(TICK_CYC + 1);

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  // An unset rank reads as low so new primes never outrank old ones.
  function automatic logic [1:0] eff_rank(input logic [1:0] c);
    return (c == UNSET) ? RANK_LOW : c;
  endfunction

  // Returns {found, rank, index}; the strict compare keeps the lowest.
  function automatic logic [5:0] pick(input logic [7:0] f,
                                      input logic [15:0] r);
    logic [5:0] b;
    logic [1:0] k;
    b = 6'h00;
    for (int i = 0; i < NPRIME; i++) begin
      k = eff_rank(r[2*i +: 2]);
      if (f[i] && (!b[5] || k < b[4:3])) begin
        b = {1'b1, k, 3'(i)};
      end
    end
    return b;
  endfunction

  // Clear-wait length in half-second ticks.
  function automatic logic [8:0] clr_wait(input logic [1:0] m,
                                          input logic [7:0] man,
                                          input logic [7:0] sw,
                                          input logic rx);
    logic [1:0] e;
    e = (m != UNSET) ? m : (rx ? RX_DLY_DFLT : TX_DLY_DFLT);
    if (e == DLY_MAN) begin
      return {1'b0, man};
    end
    if (e == DLY_AUTO && rx) begin
      return {sw, 1'b0};
    end
    return 9'h000;
  endfunction

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  logic [DW-1:0] div_q;
  logic tick;
  logic whole_q;
  logic [7:0] sweep_q;
  logic [15:0] rank_q [2];
  logic [15:0] mode_q [2];
  logic [7:0] act_q [2];
  logic [7:0] man_q [2][8];
  logic [23:0] dlmap_q;
  logic [6:0] cmd_q;
  logic busy_q, ok_q, err_q, start_q, cfgflt_q;
  logic [7:0] swf_q [2];
  logic [6:0] dlf_q, dlf_d;
  logic [9:0] comm_q, mism_q, incomp_q, miss_q;
  logic [2:0] rail_q;
  logic [1:0] psu_q;
  logic batt_q;
  logic lamp_tx_q, lamp_rx_q, lamp_sys_q, lamp_batt_q;
  bpd_st_t st_q [2];
  logic [2:0] srv_q [2];
  logic [1:0] srk_q [2];
  logic [8:0] tmr_q [2];
  logic [31:0] rd_q, rd_d;
  logic hit, wr, rd;
  logic [7:0] fl [2];
  logic [5:0] sel [2];
  logic [1:0] pre;
  logic [8:0] dly [2];
  logic [3:0] unit;

  // ------------------------------------------------------------
  // Half-second tick
  // ------------------------------------------------------------
  // One shared divider; a timer's first tick may come early, so
  // the transmit qualification wait is loaded one tick longer.
  assign tick = (div_q == DW'(TICK_CYC - 1));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= '0;
    end else begin
      div_q <= tick ? '0 : div_q + DW'(1);
    end
  end

  // ------------------------------------------------------------
  // APB slave
  // ------------------------------------------------------------
  // Zero wait states; read data is captured in the setup cycle.
  assign wr = psel && penable && pwrite;
  assign rd = psel && !penable;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign prdata = rd_q;

  always_comb begin
    hit = 1'b1;
    rd_d = 32'h0000_0000;
    if (paddr[7:6] == A_MAN_HI) begin
      rd_d = {24'h00_0000, man_q[paddr[5]][paddr[4:2]]};
    end else begin
      unique case (paddr)
        A_CTRL: rd_d = {16'h0000, sweep_q, 7'h00, whole_q};
        A_RANK_TX: rd_d = {16'h0000, rank_q[0]};
        A_RANK_RX: rd_d = {16'h0000, rank_q[1]};
        A_MODE_TX: rd_d = {16'h0000, mode_q[0]};
        A_MODE_RX: rd_d = {16'h0000, mode_q[1]};
        A_ACTIVE: rd_d = {16'h0000, act_q[1], act_q[0]};
        A_DLMAP: rd_d = {8'h00, dlmap_q};
        A_CFG: rd_d = {21'h00_0000, err_q, ok_q, busy_q, 1'b0, cmd_q};
        // Link settings are constants; software cannot alter them.
        A_LINK: rd_d = {15'h0000, LINK_EVEN, 16'(LINK_BAUD)};
        A_FLT_SW: rd_d = {9'h000, dlf_q, swf_q[1], swf_q[0]};
        A_FLT_SYS: rd_d = {2'h0, incomp_q, mism_q, comm_q};
        A_FLT_AUX: rd_d = {15'h0000, cfgflt_q, batt_q, psu_q, rail_q,
                           miss_q};
        A_STATE: rd_d = {16'h0000, st_q[1], 1'b0, srv_q[1], st_q[0],
                         1'b0, srv_q[0]};
        default: hit = 1'b0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_q <= 32'h0000_0000;
    end else if (rd) begin
      rd_q <= rd_d;
    end
  end

  // Settings; zero means not entered and falls back to defaults.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      whole_q <= 1'b0;
      sweep_q <= 8'h00;
      rank_q <= '{default: 16'h0000};
      mode_q <= '{default: 16'h0000};
      act_q <= '{default: 8'h00};
      man_q <= '{default: '{default: 8'h00}};
      dlmap_q <= 24'h00_0000;
    end else if (wr && hit) begin
      if (paddr[7:6] == A_MAN_HI) begin
        man_q[paddr[5]][paddr[4:2]] <= pwdata[7:0];
      end else begin
        unique case (paddr)
          A_CTRL: begin
            whole_q <= pwdata[0];
            sweep_q <= pwdata[SWEEP_LSB +: 8];
          end
          A_RANK_TX: rank_q[0] <= pwdata[15:0];
          A_RANK_RX: rank_q[1] <= pwdata[15:0];
          A_MODE_TX: mode_q[0] <= pwdata[15:0];
          A_MODE_RX: mode_q[1] <= pwdata[15:0];
          A_ACTIVE: {act_q[1], act_q[0]} <= pwdata[15:0];
          A_DLMAP: dlmap_q <= pwdata[23:0];
          default: ;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // Configuration load and verify
  // ------------------------------------------------------------
  // Units 0-7 are primes, 8-9 backups; commands while busy are dropped.
  assign unit = cmd_q[2] ? {3'h4, cmd_q[3]} : {1'b0, cmd_q[5:3]};
  assign cfg_start = start_q;
  assign cfg_verify = cmd_q[0];
  assign cfg_all = cmd_q[1];
  assign cfg_unit = unit;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_q <= 7'h00;
      busy_q <= 1'b0;
      ok_q <= 1'b0;
      err_q <= 1'b0;
      start_q <= 1'b0;
    end else begin
      start_q <= 1'b0;
      if (wr && paddr == A_CFG && !busy_q) begin
        cmd_q <= pwdata[6:0];
        busy_q <= 1'b1;
        start_q <= 1'b1;
      end else if (busy_q && cfg_done) begin
        busy_q <= 1'b0;
        ok_q <= cfg_pass;
        err_q <= !cfg_pass;
      end
    end
  end

  // ------------------------------------------------------------
  // System faults: sticky, write one to clear, a new set wins
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      comm_q <= 10'h000;
      mism_q <= 10'h000;
      incomp_q <= 10'h000;
      miss_q <= 10'h000;
      rail_q <= 3'h0;
      psu_q <= 2'h0;
      batt_q <= 1'b0;
      cfgflt_q <= 1'b0;
    end else begin
      logic [31:0] cs, ca;
      logic [9:0] ld;
      cs = (wr && paddr == A_FLT_SYS) ? pwdata : 32'h0000_0000;
      ca = (wr && paddr == A_FLT_AUX) ? pwdata : 32'h0000_0000;
      // A passing load makes that unit's stored setup current again.
      ld = 10'h000;
      if (busy_q && cfg_done && cfg_pass && !cmd_q[0]) begin
        ld = cmd_q[1] ? 10'h3FF : 10'(1) << unit;
      end
      comm_q <= (comm_q & ~cs[9:0]) | comm_fail;
      mism_q <= (mism_q & ~cs[19:10] & ~ld) | modem_cfg_changed;
      incomp_q <= (incomp_q & ~cs[29:20]) | incompat;
      miss_q <= (miss_q & ~ca[9:0]) | setup_missing;
      rail_q <= (rail_q & ~ca[12:10]) | rail_fail;
      psu_q <= (psu_q & ~ca[14:13]) | psu_fail;
      batt_q <= (batt_q & ~ca[15]) | battery_low;
      cfgflt_q <= (cfgflt_q & ~ca[16]) |
                  (busy_q && cfg_done && !cfg_pass);
    end
  end

  // ------------------------------------------------------------
  // Downlink and lamp summaries
  // ------------------------------------------------------------
  // A downlink with no active receiver never reports all faulted.
  always_comb begin
    logic [7:0] mem;
    mem = 8'h00;
    dlf_d = 7'h00;
    for (int d = 0; d < NDL; d++) begin
      for (int i = 0; i < NPRIME; i++) begin
        mem[i] = act_q[1][i] && dlmap_q[3*i +: 3] == 3'(d + 1);
      end
      dlf_d[d] = (|mem) && ((mem & ~rx_fault) == 8'h00);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dlf_q <= 7'h00;
      lamp_tx_q <= 1'b0;
      lamp_rx_q <= 1'b0;
      lamp_sys_q <= 1'b0;
      lamp_batt_q <= 1'b0;
    end else begin
      dlf_q <= dlf_d;
      lamp_tx_q <= |swf_q[0];
      lamp_rx_q <= (|swf_q[1]) || (|dlf_q);
      lamp_sys_q <= |{comm_q, mism_q, incomp_q, miss_q, rail_q, psu_q,
                      cfgflt_q};
      lamp_batt_q <= batt_q;
    end
  end

  assign lamp_tx = lamp_tx_q;
  assign lamp_rx = lamp_rx_q;
  assign lamp_sys = lamp_sys_q;
  assign lamp_batt = lamp_batt_q;
  assign downlink_all_rx_fault = dlf_q;
  assign tx_backup_switch_fault = swf_q[0];
  assign rx_backup_switch_fault = swf_q[1];

  // ------------------------------------------------------------
  // Backup engines: index 0 transmit, 1 receive
  // ------------------------------------------------------------
  // Whole-modem mode takes the receive rank and delay settings for both directions.
  always_comb begin
    for (int d = 0; d < 2; d++) begin
      logic w;
      w = whole_q ? 1'b1 : d[0];
      fl[d] = (d == 0 ? tx_fault : rx_fault) & act_q[d];
      sel[d] = pick(fl[d], rank_q[w]);
      pre[d] = st_q[d] != ST_IDLE && sel[d][5] &&
               sel[d][4:3] < srk_q[d];
      dly[d] = clr_wait(mode_q[w][2*srv_q[d] +: 2], man_q[w][srv_q[d]],
                        sweep_q, w);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '{default: ST_IDLE};
      srv_q <= '{default: 3'h0};
      srk_q <= '{default: RANK_LOW};
      tmr_q <= '{default: 9'h000};
      swf_q <= '{default: 8'h00};
    end else begin
      for (int d = 0; d < 2; d++) begin
        logic [7:0] setf, clrf;
        logic up;
        setf = 8'h00;
        clrf = (wr && paddr == A_FLT_SW) ? pwdata[8*d +: 8] : 8'h00;
        up = fl[d][srv_q[d]];
        if (tick && tmr_q[d] != 9'h000) begin
          tmr_q[d] <= tmr_q[d] - 9'h001;
        end
        if ((st_q[d] == ST_IDLE && sel[d][5]) || pre[d]) begin
          st_q[d] <= ST_QUAL;
          srv_q[d] <= sel[d][2:0];
          srk_q[d] <= sel[d][4:3];
          tmr_q[d] <= (d == 0) ? 9'(QUAL_TICKS + 1) :
                      {sweep_q, 1'b0};
        end else begin
          unique case (st_q[d])
            ST_IDLE: ;
            ST_QUAL: begin
              if (d == 1 && bk_rx_lock) begin
                st_q[d] <= ST_WAIT;
                tmr_q[d] <= dly[d];
              end else if (tmr_q[d] == 9'h000) begin
                if (d == 0 && up && !bk_tx_fault) begin
                  st_q[d] <= ST_WAIT;
                  tmr_q[d] <= dly[d];
                end else begin
                  st_q[d] <= ST_IDLE;
                  if (d == 1 || up) begin
                    setf[srv_q[d]] = 1'b1;
                  end
                end
              end
            end
            ST_WAIT: begin
              if (tmr_q[d] == 9'h000) begin
                st_q[d] <= up ? ST_LIVE : ST_IDLE;
              end
            end
            ST_LIVE: ;
          endcase
        end
        swf_q[d] <= (swf_q[d] & ~clrf) | setf;
      end
    end
  end

  assign tx_bk_prime = srv_q[0];
  assign rx_bk_prime = srv_q[1];
  assign tx_bk_online = st_q[0] == ST_LIVE;
  assign rx_bk_online = st_q[1] == ST_LIVE;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_tx_qual_end;
    st_q[0] == ST_QUAL && tmr_q[0] == 9'h000 && !pre[0];
  endsequence
  property p_tx_commit;
    s_tx_qual_end and (fl[0][srv_q[0]] && !bk_tx_fault)
      |=> st_q[0] == ST_WAIT;
  endproperty
  a_tx_commit: assert property (p_tx_commit)
    else $error("tx backup not committed");
  property p_tx_swf;
    s_tx_qual_end and (fl[0][srv_q[0]] && bk_tx_fault)
      |=> swf_q[0][$past(srv_q[0])] && st_q[0] == ST_IDLE;
  endproperty
  a_tx_swf: assert property (p_tx_swf)
    else $error("tx switch fault missing");
  property p_live;
    st_q[1] == ST_WAIT && tmr_q[1] == 9'h000 && !pre[1] &&
      fl[1][srv_q[1]] |=> rx_bk_online;
  endproperty
  a_live: assert property (p_live)
    else $error("rx backup not placed online");
  property p_restore;
    st_q[1] == ST_WAIT && tmr_q[1] == 9'h000 && !pre[1] &&
      !fl[1][srv_q[1]] |=> st_q[1] == ST_IDLE;
  endproperty
  a_restore: assert property (p_restore)
    else $error("cleared prime not restored");
  property p_preempt;
    pre[1] |=> st_q[1] == ST_QUAL && srv_q[1] == $past(sel[1][2:0]);
  endproperty
  a_preempt: assert property (p_preempt)
    else $error("higher rank did not take backup");
  property p_pick;
    st_q[0] == ST_IDLE && sel[0][5]
      |=> srv_q[0] == $past(sel[0][2:0]) ##1 st_q[0] == ST_QUAL;
  endproperty
  a_pick: assert property (p_pick)
    else $error("wrong channel picked");
  property p_cfg_err;
    busy_q && cfg_done && !cfg_pass |=> err_q && cfgflt_q && !busy_q;
  endproperty
  a_cfg_err: assert property (p_cfg_err)
    else $error("config failure not flagged");
  property p_mism;
    modem_cfg_changed[0] |=> mism_q[0] ##1 lamp_sys;
  endproperty
  a_mism: assert property (p_mism)
    else $error("setup mismatch not raised");
  property p_batt;
    battery_low |=> batt_q ##1 lamp_batt;
  endproperty
  a_batt: assert property (p_batt)
    else $error("battery fault not shown");
endmodule

// ---- verif/bpd_modem_model.sv ----
// Behavioural bank of prime and backup modems on the control link.
// Assumes cfg_start is a one-cycle pulse on pclk from the controller.
`timescale 1ns/10ps
module bpd_modem_model #(
  parameter int unsigned LAT = 5
) (
  input logic pclk,
  input logic presetn,
  input logic cfg_start,
  input logic cfg_all,
  input logic [3:0] cfg_unit,
  input logic [9:0] good_mask,
  output logic cfg_done,
  output logic cfg_pass
);
  int cnt_q;
  logic pass_q;
  // -----------------------------------------------------------------
  // Link answer
  // -----------------------------------------------------------------
  // Each unit answers only at its own address; all needs every unit good.
  // The link runs at a fixed rate and parity, so the answer time is fixed.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 0;
      pass_q <= 1'b0;
      cfg_done <= 1'b0;
      cfg_pass <= 1'b0;
    end else begin
      if (cfg_start) begin
        cnt_q <= LAT;
        pass_q <= cfg_all ? &good_mask : good_mask[cfg_unit];
      end else if (cnt_q != 0) begin
        cnt_q <= cnt_q - 1;
      end
      cfg_done <= (cnt_q == 1);
      // Outside an answer the result line wanders, so it must be qualified.
      cfg_pass <= (cnt_q == 1) ? pass_q : ~cfg_pass;
    end
  end
endmodule

// ---- verif/backup_priority_delay_fault_ctrl_test.sv ----
// Self-checking bench for the backup decision and fault core.
// Assumes the modem model file and the design package are compiled first.
`timescale 1ns/10ps
module backup_priority_delay_fault_ctrl_test;
  import bpd_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, slv;
  logic [7:0] paddr, tx_fault, rx_fault, tx_bsf, rx_bsf;
  logic [31:0] pwdata, prdata, q;
  logic bk_tx_fault, bk_rx_lock, tx_bk_online, rx_bk_online, battery_low;
  logic [2:0] tx_bk_prime, rx_bk_prime;
  logic cfg_start, cfg_verify, cfg_all, cfg_done, cfg_pass;
  logic [3:0] cfg_unit;
  logic [9:0] chg, comm_fail, good_mask;
  logic [6:0] dl_flt;
  logic lamp_tx, lamp_rx, lamp_sys, lamp_batt;
  int err_total = 0;
  int comparisons = 0;
  bpd_ctrl #(.TICK_CYC(8)) i_bpd_ctrl (.pclk(pclk), .presetn(presetn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tx_fault(tx_fault), .rx_fault(rx_fault), .bk_tx_fault(bk_tx_fault),
    .bk_rx_lock(bk_rx_lock), .tx_bk_prime(tx_bk_prime),
    .tx_bk_online(tx_bk_online), .rx_bk_prime(rx_bk_prime),
    .rx_bk_online(rx_bk_online), .cfg_start(cfg_start),
    .cfg_verify(cfg_verify), .cfg_all(cfg_all), .cfg_unit(cfg_unit),
    .cfg_done(cfg_done), .cfg_pass(cfg_pass), .modem_cfg_changed(chg),
    .comm_fail(comm_fail), .incompat(10'h000), .setup_missing(10'h000),
    .rail_fail(3'h0), .psu_fail(2'h0), .battery_low(battery_low),
    .tx_backup_switch_fault(tx_bsf), .rx_backup_switch_fault(rx_bsf),
    .downlink_all_rx_fault(dl_flt), .lamp_tx(lamp_tx), .lamp_rx(lamp_rx),
    .lamp_sys(lamp_sys), .lamp_batt(lamp_batt));
  bpd_modem_model i_bpd_modem_model (.pclk(pclk), .presetn(presetn),
    .cfg_start(cfg_start), .cfg_all(cfg_all), .cfg_unit(cfg_unit),
    .good_mask(good_mask), .cfg_done(cfg_done), .cfg_pass(cfg_pass));
  // -----------------------------------------------------------------
  // Tasks
  // -----------------------------------------------------------------
  // Closing report; every path that ends the run comes here.
  task automatic conclude();
    if (err_total == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // One APB transfer, entered just after a rising edge; an idle edge ends
  // it so that psel is never assigned twice in one time step.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50) begin
      @(posedge pclk);
      n++;
    end
    if (n == 50) begin
      err_total++;
      conclude();
    end
    q = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(q & m, e);
  endtask
  // Bounded wait for an output condition picked by s.
  task automatic wait_on(input int s, input int p);
    int n;
    logic hit;
    n = 0;
    hit = 1'b0;
    while (!hit && n < 400) begin
      @(posedge pclk);
      n++;
      case (s)
        0: hit = tx_bk_online === 1'b1 && tx_bk_prime === p[2:0];
        1: hit = tx_bsf[p] === 1'b1;
        2: hit = dl_flt[p] === 1'b1;
        4: hit = rx_bsf[p] === 1'b1;
        default: hit = rx_bk_online === 1'b1 && rx_bk_prime === p[2:0];
      endcase
    end
    chk({31'h0, hit}, 32'h1);
    if (!hit) begin
      conclude();
    end
  endtask
  // A load or verify command, polled until idle, then its ok/err bits.
  task automatic cfg(input logic [31:0] c, input logic [31:0] e);
    int n;
    n = 0;
    apb(1'b1, A_CFG, c);
    q = 32'h100;
    while (q[8] !== 1'b0 && n < 20) begin
      apb(1'b0, A_CFG, 32'h0);
      n++;
    end
    chk(q & 32'h700, e);
  endtask
  // -----------------------------------------------------------------
  // Clock and watchdog
  // -----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  initial begin
    repeat (100000) @(posedge pclk);
    err_total++;
    conclude();
  end
  // -----------------------------------------------------------------
  // Main sequence
  // -----------------------------------------------------------------
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {tx_fault, rx_fault, bk_tx_fault, bk_rx_lock, battery_low} = '0;
    {chg, comm_fail} = '0;
    good_mask = 10'h3FF;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rchk(A_LINK, 32'h1FFFF, 32'h12580);
    rchk(8'h34, 32'hFFFFFFFF, 32'h0);
    chk({31'h0, slv}, 32'h1);
    rchk(A_STATE, 32'hF0F0, 32'h1010);
    apb(1'b1, A_ACTIVE, 32'hFFFF);
    apb(1'b1, A_CTRL, 32'h400);
    apb(1'b1, A_RANK_TX, 32'h400);
    bk_tx_fault <= 1'b1;
    tx_fault <= 8'h01;
    wait_on(1, 0);
    bk_tx_fault <= 1'b0;
    tx_fault <= 8'h00;
    // The lamp trails the sticky bit by one cycle.
    @(posedge pclk);
    chk({31'h0, lamp_tx}, 32'h1);
    apb(1'b1, A_FLT_SW, 32'h1);
    rchk(A_FLT_SW, 32'h1, 32'h0);
    tx_fault <= 8'h04;
    wait_on(0, 2);
    tx_fault <= 8'h24;
    wait_on(0, 5);
    apb(1'b1, 8'h64, 32'h4);
    apb(1'b1, A_MODE_RX, 32'h8);
    bk_rx_lock <= 1'b1;
    rx_fault <= 8'h02;
    repeat (12) @(posedge pclk);
    rx_fault <= 8'h00;
    repeat (100) @(posedge pclk);
    chk({31'h0, rx_bk_online}, 32'h0);
    rx_fault <= 8'h02;
    wait_on(3, 1);
    apb(1'b1, A_DLMAP, 32'h9);
    // The summary is registered; let the new map reach it first.
    repeat (2) @(posedge pclk);
    chk({25'h0, dl_flt}, 32'h0);
    rx_fault <= 8'h03;
    wait_on(2, 0);
    chg <= 10'h009;
    comm_fail[9] <= 1'b1;
    @(posedge pclk);
    chg <= 10'h0;
    comm_fail <= 10'h0;
    @(posedge pclk);
    chk({31'h0, lamp_rx}, 32'h1);
    rchk(A_FLT_SYS, 32'h2200, 32'h2200);
    cfg(32'h18, 32'h200);
    rchk(A_FLT_SYS, 32'h2000, 32'h0);
    good_mask[4] <= 1'b0;
    cfg(32'h3, 32'h400);
    chk({31'h0, cfg_verify}, 32'h1);
    rchk(A_FLT_AUX, 32'h10000, 32'h10000);
    chk({31'h0, lamp_sys}, 32'h1);
    cfg(32'hC, 32'h200);
    // A high-rank receiver takes the backup, which then never locks.
    apb(1'b1, A_RANK_RX, 32'h10);
    bk_rx_lock <= 1'b0;
    rx_fault <= 8'h07;
    wait_on(4, 2);
    battery_low <= 1'b1;
    repeat (3) @(posedge pclk);
    rchk(A_FLT_AUX, 32'h8000, 32'h8000);
    chk({31'h0, lamp_batt}, 32'h1);
    conclude();
  end
endmodule
